// ### rtl/cwf_params.svh
/*
  Offsets, field positions and reset values of the comparator window filter.
  Assumes AXI4-Lite with 32-bit data and one register per aligned word.
*/
`ifndef CWF_PARAMS_SVH
`define CWF_PARAMS_SVH
`define CWF_OFF_CTRL      8'h00
`define CWF_OFF_FILT      8'h04
`define CWF_OFF_STAT      8'h08
`define CWF_CTRL_ACTIVE   0
`define CWF_CTRL_FLIP     1
`define CWF_CTRL_GATE     2
`define CWF_CTRL_EXT      3
`define CWF_FILT_CNT_LSB  0
`define CWF_SAMPLE_PERIOD_LSB  8
`define CWF_STAT_FINAL    0
`define CWF_STAT_GATED    1
`define CWF_STAT_RISE     2
`define CWF_STAT_FALL     3
`define CWF_STAT_RISE_ON  4
`define CWF_STAT_FALL_ON  5
`define CWF_RST_CTRL      4'h0
`define CWF_RST_BYTE      8'h00
`endif

// ### rtl/cwf_pkg.sv
/*
  Types of the comparator window filter.
  Assumes nothing beyond the parameter header.
*/
package cwf_pkg;
  typedef logic [1:0] cwf_resp_type;
  localparam cwf_resp_type CWF_OKAY   = 2'h0;
  localparam cwf_resp_type CWF_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CWF_SRC_NONE = 2'b00,
    CWF_SRC_EXT  = 2'b01,
    CWF_SRC_DIV  = 2'b10
  } cwf_src_type;
endpackage

// ### rtl/cwf_top.sv
/*
  Digital back end of an analog comparator: polarity, window gating,
  sampling filter, edge flags, interrupt request, AXI4-Lite registers.
  Assumes analog_result, window_strobe and sample_strobe are synchronous
  to aclk.
*/
`timescale 1ns/10ps
`include "cwf_params.svh"

module cwf_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        analog_result,
  input  wire logic        window_strobe,
  input  wire logic        sample_strobe,
  output logic             final_output,
  output logic             gated_raw_output,
  output logic             irq
);
  logic [3:0]  ctrl;
  logic [7:0]  agree_count;
  logic [7:0]  sample_period;
  logic        rise_flag;
  logic        fall_flag;
  logic        rise_irq_on;
  logic        fall_irq_on;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        gated_q;
  logic        filt_out;
  logic [7:0]  agree_run;
  logic [7:0]  div_cnt;
  logic        strobe_prev;
  logic        final_prev;

  wire active           = ctrl[`CWF_CTRL_ACTIVE];
  wire polarity_flip    = ctrl[`CWF_CTRL_FLIP];
  wire gate_on          = ctrl[`CWF_CTRL_GATE];
  wire ext_trigger_pick = ctrl[`CWF_CTRL_EXT];

  // comparator stage
  wire cmp = active & (analog_result ^ polarity_flip);
  assign gated_raw_output = gate_on ? gated_q : cmp;

  // filter source selection
  wire filt_en = (agree_count != 8'h00) & (ext_trigger_pick | (sample_period != 8'h00));
  cwf_pkg::cwf_src_type src;
  assign src = !filt_en ? cwf_pkg::CWF_SRC_NONE :
               ext_trigger_pick ? cwf_pkg::CWF_SRC_EXT : cwf_pkg::CWF_SRC_DIV;
  wire ext_tick = sample_strobe & ~strobe_prev;
  wire div_tick = (div_cnt == sample_period - 8'h01);
  logic tick;
  always_comb begin
    case (src)
      cwf_pkg::CWF_SRC_EXT: tick = ext_tick;
      cwf_pkg::CWF_SRC_DIV: tick = div_tick;
      default:              tick = 1'b0;
    endcase
  end
  wire differs    = gated_raw_output != filt_out;
  wire agree_done = (agree_run + 8'h01) >= agree_count;
  wire final_pre  = filt_en ? filt_out : gated_raw_output;
  assign final_output = final_pre;
  wire rise_evt = final_pre & ~final_prev;
  wire fall_evt = ~final_pre & final_prev;
  assign irq = (rise_flag & rise_irq_on) | (fall_flag & fall_irq_on);

  // bus decode
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl  = do_write & (aw_addr == `CWF_OFF_CTRL) & w_strb[0];
  wire wr_cnt   = do_write & (aw_addr == `CWF_OFF_FILT) & w_strb[0];
  wire wr_per   = do_write & (aw_addr == `CWF_OFF_FILT) & w_strb[1];
  wire wr_stat  = do_write & (aw_addr == `CWF_OFF_STAT) & w_strb[0];
  wire wr_hit   = (aw_addr == `CWF_OFF_CTRL) | (aw_addr == `CWF_OFF_FILT) |
                  (aw_addr == `CWF_OFF_STAT);
  wire clr_rise = wr_stat & w_data[`CWF_STAT_RISE];
  wire clr_fall = wr_stat & w_data[`CWF_STAT_FALL];
  wire rd_hit   = (s_axi_araddr == `CWF_OFF_CTRL) | (s_axi_araddr == `CWF_OFF_FILT) |
                  (s_axi_araddr == `CWF_OFF_STAT);
  wire [31:0] stat_word = {26'h0000000, fall_irq_on, rise_irq_on, fall_flag, rise_flag,
                           gated_raw_output, final_pre};
  wire [31:0] rd_mux = (s_axi_araddr == `CWF_OFF_CTRL) ? {28'h0000000, ctrl} :
                       (s_axi_araddr == `CWF_OFF_FILT) ? {16'h0000, sample_period, agree_count} :
                       (s_axi_araddr == `CWF_OFF_STAT) ? stat_word : 32'h00000000;
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cwf_pkg::CWF_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'h0};
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? cwf_pkg::CWF_OKAY : cwf_pkg::CWF_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= cwf_pkg::CWF_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? cwf_pkg::CWF_OKAY : cwf_pkg::CWF_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl          <= `CWF_RST_CTRL;
      agree_count   <= `CWF_RST_BYTE;
      sample_period <= `CWF_RST_BYTE;
      rise_irq_on   <= 1'b0;
      fall_irq_on   <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= w_data[3:0];
      if (wr_cnt) agree_count <= w_data[`CWF_FILT_CNT_LSB +: 8];
      if (wr_per) sample_period <= w_data[`CWF_SAMPLE_PERIOD_LSB +: 8];
      if (wr_stat) begin
        rise_irq_on <= w_data[`CWF_STAT_RISE_ON];
        fall_irq_on <= w_data[`CWF_STAT_FALL_ON];
      end
    end
  end

  // edge flags: a new edge wins over a clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_flag  <= 1'b0;
      fall_flag  <= 1'b0;
      final_prev <= 1'b0;
    end else begin
      final_prev <= final_pre;
      rise_flag  <= rise_evt | (rise_flag & ~clr_rise);
      fall_flag  <= fall_evt | (fall_flag & ~clr_fall);
    end
  end

  // window latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gated_q <= 1'b0;
    end else if (window_strobe) begin
      gated_q <= cmp;
    end
  end

  // sampling filter; disabled settings return it to a known zero state
  always_ff @(posedge aclk) begin
    if (!aresetn || !filt_en) begin
      filt_out    <= 1'b0;
      agree_run   <= 8'h00;
      div_cnt     <= 8'h00;
      strobe_prev <= 1'b0;
    end else begin
      strobe_prev <= sample_strobe;
      div_cnt     <= div_tick ? 8'h00 : div_cnt + 8'h01;
      if (tick) begin
        if (!differs) begin
          agree_run <= 8'h00;
        end else if (agree_done) begin
          filt_out  <= gated_raw_output;
          agree_run <= 8'h00;
        end else begin
          agree_run <= agree_run + 8'h01;
        end
      end
    end
  end

  property p_continuous;
    @(posedge aclk) disable iff (!aresetn)
    (!gate_on && !filt_en) |-> final_output == (active & (analog_result ^ polarity_flip));
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous path wrong");

  property p_disabled;
    @(posedge aclk) disable iff (!aresetn)
    (!active && !gate_on && !filt_en) |-> !final_output;
  endproperty
  a_disabled: assert property (p_disabled) else $error("inactive output not zero");

  property p_rise;
    @(posedge aclk) disable iff (!aresetn)
    (final_output && !$past(final_output)) |=> rise_flag;
  endproperty
  a_rise: assert property (p_rise) else $error("rise flag missed");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    (fall_flag && fall_irq_on) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
    (gate_on && !window_strobe) ##1 gate_on |-> $stable(gated_raw_output);
  endproperty
  a_hold: assert property (p_hold) else $error("window value not held");

  property p_window;
    @(posedge aclk) disable iff (!aresetn)
    (gate_on && window_strobe) ##1 gate_on |-> gated_raw_output == $past(cmp);
  endproperty
  a_window: assert property (p_window) else $error("window sample wrong");

  property p_filt_zero;
    @(posedge aclk) disable iff (!aresetn)
    !filt_en |=> !filt_out;
  endproperty
  a_filt_zero: assert property (p_filt_zero) else $error("filter not cleared");

  property p_change_on_tick;
    @(posedge aclk) disable iff (!aresetn)
    (filt_en && $past(filt_en) && $changed(filt_out)) |-> $past(tick);
  endproperty
  a_change_on_tick: assert property (p_change_on_tick) else $error("filter moved off tick");

  property p_sampler;
    @(posedge aclk) disable iff (!aresetn)
    (filt_en && agree_count == 8'h01 && tick) ##1 filt_en |-> filt_out == $past(gated_raw_output);
  endproperty
  a_sampler: assert property (p_sampler) else $error("sampler missed sample");

  property p_ext_tick;
    @(posedge aclk) disable iff (!aresetn)
    (filt_en && ext_trigger_pick && $past(filt_en) && sample_strobe && !$past(sample_strobe))
      |-> tick;
  endproperty
  a_ext_tick: assert property (p_ext_tick) else $error("strobe rise not sampled");

  property p_div_tick;
    @(posedge aclk) disable iff (!aresetn)
    (filt_en && !ext_trigger_pick && tick) ##1 (filt_en && $stable(ctrl) && $stable(sample_period))
      |-> (sample_period == 8'h01) || !tick;
  endproperty
  a_div_tick: assert property (p_div_tick) else $error("divider ticked twice");
endmodule // cwf_top

// ### tb/cwf_far_side.sv
/*
  Far-side model: comparator core and timer strobe source.
  Assumes the bench sets level and strobes; it registers them on aclk.
*/
`timescale 1ns/10ps
module cwf_far_side (
  input  wire logic aclk,
  input  wire logic lvl,
  input  wire logic win,
  input  wire logic smp,
  output logic      analog_result,
  output logic      window_strobe,
  output logic      sample_strobe
);
  always_ff @(posedge aclk) begin
    analog_result <= lvl;
    window_strobe <= win;
    sample_strobe <= smp;
  end
endmodule // cwf_far_side

// ### tb/test_comparator_window_filter.sv
/*
  Bench for cwf_top: register tasks, mode table, edge, window, filter cases.
  Assumes cwf_far_side drives the comparator link.
*/
`timescale 1ns/10ps
`include "cwf_params.svh"
module test_comparator_window_filter;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs, bs;
  logic        lvl, win, smp, ar, ws, ss, fo, go, irq;
  logic [5:0]  rows [6] = '{6'h02, 6'h07, 6'h04, 6'h0E, 6'h0D, 6'h08};
  int          bad_count, compares, n, k;

  cwf_far_side u_far (.aclk(aclk), .lvl(lvl), .win(win), .smp(smp),
    .analog_result(ar), .window_strobe(ws), .sample_strobe(ss));
  cwf_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .analog_result(ar), .window_strobe(ws),
    .sample_strobe(ss), .final_output(fo), .gated_raw_output(go), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic close_out;
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_up(input int cnt);
    if (cnt >= 50) begin
      bad_count++;
      close_out;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bs = bresp;
    bready <= 1'b0;
    give_up(n);
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    give_up(n);
  endtask

  task automatic drive(input logic l, input logic w, input logic s, input int c);
    @(posedge aclk);
    lvl <= l;
    win <= w;
    smp <= s;
    repeat (c) @(posedge aclk);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, lvl, win, smp} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    bad_count = 0;
    compares = 0;
    repeat (6) @(posedge aclk);
    check({fo, go, irq}, 3'h0);
    aresetn <= 1'b1;
    // unmapped write must be refused and leave the registers alone
    wr(8'hFC, 32'h0000000F);
    check(bs, cwf_pkg::CWF_SLVERR);
    rdr(`CWF_OFF_CTRL);
    check(rd, 32'h0);
    rdr(`CWF_OFF_FILT);
    check(rd, 32'h0);
    rdr(8'hFC);
    check(rs, cwf_pkg::CWF_SLVERR);
    for (k = 0; k < 6; k++) begin
      wr(`CWF_OFF_CTRL, {28'h0, rows[k][5:2]});
      drive(rows[k][1], 1'b0, 1'b0, 3);
      check(fo, rows[k][0]);
      check(go, fo);
      rdr(`CWF_OFF_STAT);
      check(rd[0], rows[k][0]);
    end
    // edge flags, clearing writes and interrupt enables, continuous mode
    wr(`CWF_OFF_CTRL, 32'h1);
    check(bs, cwf_pkg::CWF_OKAY);
    wr(`CWF_OFF_STAT, 32'h1C);
    drive(1'b1, 1'b0, 1'b0, 4);
    check(irq, 1'b1);
    rdr(`CWF_OFF_STAT);
    check(rd[3:2], 2'h1);
    drive(1'b0, 1'b0, 1'b0, 4);
    rdr(`CWF_OFF_STAT);
    check(rd[3:2], 2'h3);
    wr(`CWF_OFF_STAT, 32'h2C);
    check(irq, 1'b0);
    drive(1'b1, 1'b0, 1'b0, 4);
    check(irq, 1'b0);
    // window stage, period zero
    wr(`CWF_OFF_CTRL, 32'h0);
    wr(`CWF_OFF_CTRL, 32'h5);
    drive(1'b1, 1'b0, 1'b0, 4);
    check(go, 1'b0);
    check(irq, 1'b1);
    drive(1'b1, 1'b1, 1'b0, 3);
    check({go, fo}, 2'h3);
    drive(1'b0, 1'b0, 1'b0, 4);
    check(go, 1'b1);
    // windowed resample, period 4
    wr(`CWF_OFF_FILT, 32'h0401);
    drive(1'b0, 1'b1, 1'b0, 12);
    check(fo, 1'b0);
    drive(1'b1, 1'b1, 1'b0, 12);
    check(fo, 1'b1);
    wr(`CWF_OFF_FILT, 32'h0);
    wr(`CWF_OFF_CTRL, 32'h1);
    // divided clock, period 8, single sample
    wr(`CWF_OFF_FILT, 32'h0801);
    drive(1'b1, 1'b0, 1'b0, 0);
    for (k = 0; k < 50 && fo !== 1'b1; k++) @(posedge aclk);
    give_up(k);
    lvl <= 1'b0;
    for (k = 0; k < 50 && fo !== 1'b0; k++) @(posedge aclk);
    check(k, 8);
    // clear filter before new settings
    wr(`CWF_OFF_FILT, 32'h0);
    wr(`CWF_OFF_FILT, 32'h0003);
    wr(`CWF_OFF_CTRL, 32'h9);
    drive(1'b1, 1'b0, 1'b0, 2);
    repeat (2) begin
      drive(1'b1, 1'b0, 1'b1, 0);
      drive(1'b1, 1'b0, 1'b0, 2);
    end
    check(fo, 1'b0);
    drive(1'b1, 1'b0, 1'b1, 0);
    drive(1'b1, 1'b0, 1'b0, 3);
    check(fo, 1'b1);
    // reset in mid-run returns a configured block to its idle state
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check({fo, go, irq}, 3'h0);
    rdr(`CWF_OFF_FILT);
    check(rd, 32'h0);
    close_out;
  end
endmodule // test_comparator_window_filter
